/* File: rtl/macsa_map.vh */
// register map, field layout and bus codes for the station address register pair
`ifndef MACSA_MAP_VH
`define MACSA_MAP_VH

// address decode
`define MACSA_ADDR_W 8
`define MACSA_WORD_ONE_OFS 8'h00
`define MACSA_WORD_TWO_OFS 8'h10
`define MACSA_REG_SEL_BIT 4
`define MACSA_ALIAS_HI 3
`define MACSA_ALIAS_LO 2
`define MACSA_ADDR_TOP_HI 7
`define MACSA_ADDR_TOP_LO 5

// alias offsets inside one register block
`define MACSA_ALIAS_PLAIN 2'h0
`define MACSA_ALIAS_CLEAR 2'h1
`define MACSA_ALIAS_SET 2'h2
`define MACSA_ALIAS_INVERT 2'h3

// field layout
`define MACSA_FIELD_W 16
`define MACSA_OCTET_HI_MSB 15
`define MACSA_OCTET_HI_LSB 8
`define MACSA_OCTET_LO_MSB 7
`define MACSA_OCTET_LO_LSB 0

// byte strobe patterns of the accepted access widths
`define MACSA_STRB_WORD 4'hf
`define MACSA_STRB_HALF_LO 4'h3
`define MACSA_STRB_HALF_HI 4'hc

// bus responses
`define MACSA_RESP_OKAY 2'h0
`define MACSA_RESP_SLVERR 2'h2

// neutral factory address, arbitrary value
`define MACSA_FACTORY_DEFAULT 32'h02000001

`endif

/* File: rtl/macsa_cell.v */
// one 16-bit station address register with write, clear, set and invert aliases
`timescale 1ns/1ns
`default_nettype none
`include "macsa_map.vh"

module macsa_cell #(
    parameter [15:0] RESET_VALUE = 16'h0000
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // write request
    input wire wr_en,
    input wire [1:0] wr_alias,
    input wire [1:0] lane_en,
    input wire [15:0] wr_data,
    // stored value
    output reg [15:0] value
);

    wire [15:0] lane_mask;
    wire [15:0] masked;
    reg [15:0] next_value;

    assign lane_mask = {{8{lane_en[1]}}, {8{lane_en[0]}}};
    assign masked = wr_data & lane_mask;

    // lanes without strobe keep their bits in every alias
    always @* begin
        case (wr_alias)
            `MACSA_ALIAS_PLAIN: next_value = (value & ~lane_mask) | masked;
            `MACSA_ALIAS_CLEAR: next_value = value & ~masked;
            `MACSA_ALIAS_SET: next_value = value | masked;
            `MACSA_ALIAS_INVERT: next_value = value ^ masked;
            default: next_value = value;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            value <= RESET_VALUE;
        end else if (wr_en) begin
            value <= next_value;
        end
    end

endmodule

`default_nettype wire

/* File: rtl/macsa_regs.v */
// station address register pair with an AXI4-Lite slave and the address handed to the MAC
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "macsa_map.vh"

// Operation
// - word one bits 15:8 hold octet four
// - word one bits 7:0 hold octet three
// - word two bits 15:8 hold octet two
// - word two bits 7:0 hold octet one
// - 32-bit and low-half 16-bit accesses act, aliases included
// - 8-bit accesses are ignored, contents unchanged
// - reset loads the factory station address
// - word one bits 31:16 read zero
module macsa_regs #(
    // factory address, octet one in bits 31:24 down to octet four in 7:0
    parameter [31:0] FACTORY_STATION_ADDR = `MACSA_FACTORY_DEFAULT
) (
    // clock and reset
    input wire CLK,
    input wire SYS_RST,
    // write address channel
    input wire [7:0] S_AXI_AWADDR,
    input wire [2:0] S_AXI_AWPROT,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    // write data channel
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    // write response channel
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    // read address channel
    input wire [7:0] S_AXI_ARADDR,
    input wire [2:0] S_AXI_ARPROT,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    // read data channel
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY,
    // station address towards the MAC, first transmitted octet in 31:24
    output reg [31:0] STATION_ADDR_HEAD
);

    // word one keeps octet four above octet three, the reverse of the parameter's order
    localparam [15:0] WORD_ONE_RESET = {FACTORY_STATION_ADDR[7:0], FACTORY_STATION_ADDR[15:8]};
    localparam [15:0] WORD_TWO_RESET = {FACTORY_STATION_ADDR[23:16], FACTORY_STATION_ADDR[31:24]};

    // write path state
    reg aw_held;
    reg [7:0] aw_addr;
    reg w_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    // decoded write
    wire wr_fire;
    wire wr_addr_ok;
    wire wr_width_ok;
    wire [1:0] wr_lane_en;
    wire [1:0] wr_alias;
    wire [1:0] wr_sel;

    // decoded read
    wire rd_fire;
    wire rd_addr_ok;
    reg [31:0] rd_word;

    // register contents, word one in the low half
    wire [15:0] word_one;
    wire [15:0] word_two;
    wire [31:0] cell_bits;

    // both prot inputs carry no meaning here
    wire unused_prot;
    assign unused_prot = ^{S_AXI_AWPROT, S_AXI_ARPROT};

    // ------------------------------------------------------------------
    // write address and data are captured independently, in either order

    always @(posedge CLK) begin
        if (SYS_RST) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always @(posedge CLK) begin
        if (SYS_RST) begin
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // ready is registered; it drops on the taking edge so each channel holds one item
    always @(posedge CLK) begin
        if (SYS_RST) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
        end else begin
            S_AXI_AWREADY <= !aw_held && !(S_AXI_AWVALID && S_AXI_AWREADY) && !S_AXI_BVALID;
            S_AXI_WREADY <= !w_held && !(S_AXI_WVALID && S_AXI_WREADY) && !S_AXI_BVALID;
        end
    end

    // the write lands one edge after both halves are held
    assign wr_fire = aw_held && w_held && !S_AXI_BVALID;

    assign wr_addr_ok = (aw_addr[`MACSA_ADDR_TOP_HI:`MACSA_ADDR_TOP_LO] == 3'h0) &&
                        (aw_addr[1:0] == 2'h0);
    assign wr_alias = aw_addr[`MACSA_ALIAS_HI:`MACSA_ALIAS_LO];

    // the bus gives no size, so the width is read from the strobes;
    // a single-lane or ragged strobe pattern counts as a byte access
    assign wr_width_ok = (w_strb == `MACSA_STRB_WORD) ||
                         (w_strb == `MACSA_STRB_HALF_LO) ||
                         (w_strb == `MACSA_STRB_HALF_HI);

    // only the low half is implemented; an upper-half access reaches no stored bit
    assign wr_lane_en = wr_width_ok ? w_strb[1:0] : 2'h0;

    assign wr_sel[0] = wr_fire && wr_addr_ok && !aw_addr[`MACSA_REG_SEL_BIT];
    assign wr_sel[1] = wr_fire && wr_addr_ok && aw_addr[`MACSA_REG_SEL_BIT];

    always @(posedge CLK) begin
        if (SYS_RST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `MACSA_RESP_OKAY;
        end else if (wr_fire) begin
            S_AXI_BVALID <= 1'b1;
            // an ignored byte write still completes cleanly
            S_AXI_BRESP <= wr_addr_ok ? `MACSA_RESP_OKAY : `MACSA_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // register cells, word one first

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_word
            macsa_cell #(
                .RESET_VALUE((g == 0) ? WORD_ONE_RESET : WORD_TWO_RESET)
            ) u_cell (
                .clk(CLK),
                .rst(SYS_RST),
                .wr_en(wr_sel[g]),
                .wr_alias(wr_alias),
                .lane_en(wr_lane_en),
                .wr_data(w_data[15:0]),
                .value(cell_bits[g*16 +: 16])
            );
        end
    endgenerate

    assign word_one = cell_bits[15:0];
    assign word_two = cell_bits[31:16];

    // ------------------------------------------------------------------
    // read path: one outstanding read, answered on the edge that takes it

    assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
    assign rd_addr_ok = (S_AXI_ARADDR[`MACSA_ADDR_TOP_HI:`MACSA_ADDR_TOP_LO] == 3'h0) &&
                        (S_AXI_ARADDR[1:0] == 2'h0);

    // every alias reads back the register it belongs to;
    // upper half of both words is never stored and reads zero
    always @* begin
        if (!rd_addr_ok) begin
            rd_word = 32'h00000000;
        end else if (S_AXI_ARADDR[`MACSA_REG_SEL_BIT]) begin
            rd_word = {16'h0000, word_two};
        end else begin
            rd_word = {16'h0000, word_one};
        end
    end

    always @(posedge CLK) begin
        if (SYS_RST) begin
            S_AXI_ARREADY <= 1'b0;
        end else begin
            S_AXI_ARREADY <= !S_AXI_RVALID && !rd_fire;
        end
    end

    always @(posedge CLK) begin
        if (SYS_RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= `MACSA_RESP_OKAY;
        end else if (rd_fire) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_word;
            S_AXI_RRESP <= rd_addr_ok ? `MACSA_RESP_OKAY : `MACSA_RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // address to the MAC; registered so it follows a write by one edge

    always @(posedge CLK) begin
        if (SYS_RST) begin
            STATION_ADDR_HEAD <= FACTORY_STATION_ADDR;
        end else begin
            STATION_ADDR_HEAD[31:24] <= word_two[`MACSA_OCTET_LO_MSB:`MACSA_OCTET_LO_LSB];
            STATION_ADDR_HEAD[23:16] <= word_two[`MACSA_OCTET_HI_MSB:`MACSA_OCTET_HI_LSB];
            STATION_ADDR_HEAD[15:8] <= word_one[`MACSA_OCTET_LO_MSB:`MACSA_OCTET_LO_LSB];
            STATION_ADDR_HEAD[7:0] <= word_one[`MACSA_OCTET_HI_MSB:`MACSA_OCTET_HI_LSB];
        end
    end

endmodule

`default_nettype wire

/* File: testbench/macsa_regs_sva.sv */
// port assertions for the station address register pair
`timescale 1ns/1ns
`default_nettype none
module macsa_regs_sva #(
    parameter [31:0] FACTORY_STATION_ADDR = 32'h0
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // bus
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_RVALID,
    input wire logic [31:0] S_AXI_RDATA,
    // towards the mac
    input wire logic [31:0] STATION_ADDR_HEAD
);
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    wire go = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    wire full = go && S_AXI_WSTRB == 4'hf;
    // head carries each word byte-swapped
    wire [15:0] sw = {S_AXI_WDATA[7:0], S_AXI_WDATA[15:8]};
    wire [31:0] hd = STATION_ADDR_HEAD;
    AST_WORD_ONE: assert property (full && S_AXI_AWADDR == 8'h00 |-> ##3 hd[15:0] == $past(sw, 3))
        else $error("word one write not on head");
    AST_WORD_TWO: assert property (full && S_AXI_AWADDR == 8'h10 |-> ##3 hd[31:16] == $past(sw, 3))
        else $error("word two write not on head");
    AST_SET_ALIAS: assert property (full && S_AXI_AWADDR == 8'h08 |-> ##3 hd[15:0] == ($past(hd[15:0], 3) | $past(sw, 3)))
        else $error("set alias wrong");
    AST_INV_ALIAS: assert property (full && S_AXI_AWADDR == 8'h1c |-> ##3 hd[31:16] == ($past(hd[31:16], 3) ^ $past(sw, 3)))
        else $error("invert alias wrong");
    AST_BYTE_IGNORED: assert property (go && !(S_AXI_WSTRB inside {4'hf, 4'h3, 4'hc}) |=> $stable(hd)[*3])
        else $error("byte write changed head");
    AST_RESET_LOAD: assert property ($fell(SYS_RST) |-> hd == FACTORY_STATION_ADDR)
        else $error("head not factory after reset");
    AST_TOP_ZERO: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0)
        else $error("read top half not zero");
    // write lands one edge after the taking edge, so bvalid is first seen two edges on
    AST_WRITE_ANSWER: assert property (go |-> ##2 S_AXI_BVALID)
        else $error("write not answered");
endmodule
bind macsa_regs macsa_regs_sva #(.FACTORY_STATION_ADDR(FACTORY_STATION_ADDR)) u_sva (
    .CLK(CLK), .SYS_RST(SYS_RST), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RDATA(S_AXI_RDATA), .STATION_ADDR_HEAD(STATION_ADDR_HEAD)
);
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench for the station address register pair
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam [31:0] FAC = 32'h02000001;
    logic clk = 0, rst = 1, av = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic awr, wr, bv, arr, rv;
    logic [7:0] aa = 0, ra = 0;
    logic [31:0] wd = 0, rdat, head;
    logic [3:0] ws = 0;
    logic [1:0] bresp, rresp;
    logic [15:0] w1, w2;
    logic [3:0] tab [8] = '{4'hf, 4'h3, 4'hc, 4'h1, 4'h2, 4'h4, 4'h8, 4'h6};
    int fails = 0, n_checks = 0, cyc = 0;
    macsa_regs #(.FACTORY_STATION_ADDR(FAC)) u_dut (
        .CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(aa), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(av),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ra), .S_AXI_ARPROT(3'h0),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .STATION_ADDR_HEAD(head)
    );
    always #20 clk = ~clk;
    task final_report;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // a hang ends the run as a failure
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            fails++;
            final_report;
        end
    end
    task chk(input [31:0] seen, input [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr_bus(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
        logic ga, gw;
        logic [1:0] rs;
        begin
            aa <= a; wd <= d; ws <= s; av <= 1; wv <= 1; br <= 1;
            do begin
                @(negedge clk); ga = awr && av; gw = wr && wv;
                @(posedge clk); if (ga) av <= 0; if (gw) wv <= 0;
            end while ((av && !ga) || (wv && !gw));
            do begin @(negedge clk); ga = bv; rs = bresp; @(posedge clk); end while (!ga);
            chk({30'h0, rs}, {30'h0, er}, "bresp");
            br <= 0;
            @(posedge clk);
        end
    endtask
    task rd_bus(input [7:0] a, output [31:0] d, output [1:0] r);
        logic g;
        begin
            ra <= a; arv <= 1; rr <= 1;
            do begin @(negedge clk); g = arr; @(posedge clk); end while (!g);
            arv <= 0;
            do begin @(negedge clk); g = rv; d = rdat; r = rresp; @(posedge clk); end while (!g);
            rr <= 0;
            @(posedge clk);
        end
    endtask
    // model of one word under the four aliases; only 32-bit and low-half 16-bit strobes act
    function [15:0] upd(input [15:0] o, input [1:0] al, input [15:0] d, input [3:0] s);
        logic [15:0] m;
        begin
            m = (s == 4'hf || s == 4'h3) ? {{8{s[1]}}, {8{s[0]}}} : 16'h0;
            case (al)
                2'h0: upd = (o & ~m) | (d & m);
                2'h1: upd = o & ~(d & m);
                2'h2: upd = o | (d & m);
                default: upd = o ^ (d & m);
            endcase
        end
    endfunction
    task check_all;
        logic [31:0] d, h;
        logic [1:0] r;
        begin
            rd_bus(8'h00, d, r);
            chk(d, {16'h0, w1}, "word one");
            chk({30'h0, r}, 32'h0, "word one rresp");
            rd_bus(8'h10, d, r);
            chk(d, {16'h0, w2}, "word two");
            chk({30'h0, r}, 32'h0, "word two rresp");
            // head is sampled away from the edge that launches it
            @(negedge clk);
            h = head;
            @(posedge clk);
            chk(h, {w2[7:0], w2[15:8], w1[7:0], w1[15:8]}, "head");
        end
    endtask
    task reset_run;
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        w1 = {FAC[7:0], FAC[15:8]};
        w2 = {FAC[23:16], FAC[31:24]};
        check_all;
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        void'($urandom(70));
        reset_run;
        // every alias of both words under each of the eight strobe patterns in tab
        for (int i = 0; i < 64; i++) begin
            d = $urandom;
            if (i[2]) d[31:16] = 16'h0;
            wr_bus({3'h0, i[2], i[1:0], 2'h0}, d, tab[i[5:3]], 2'h0);
            if (i[2]) w2 = upd(w2, i[1:0], d[15:0], tab[i[5:3]]);
            else w1 = upd(w1, i[1:0], d[15:0], tab[i[5:3]]);
            check_all;
        end
        // unmapped places are refused and change nothing
        wr_bus(8'h20, 32'hffffffff, 4'hf, 2'h2);
        rd_bus(8'h02, d, r);
        chk(d, 32'h0, "unmapped read");
        chk({30'h0, r}, 32'h2, "unmapped rresp");
        check_all;
        reset_run;
        final_report;
    end
endmodule
`default_nettype wire
